// ==== verilog/uio_pkg.sv ====
// package: constants and types for the uart interrupt and overrun logic
`default_nettype none
package uio_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] ADDR_TXDATA = 4'h0;
	localparam logic [3:0] ADDR_RXDATA = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_CTRL = 4'h3;
	localparam logic [3:0] ADDR_DIVLO = 4'h4;
	localparam logic [3:0] ADDR_DIVHI = 4'h5;
	localparam logic [3:0] ADDR_ADDR = 4'h6;
	// status field positions
	localparam int ST_RDA = 7;
	localparam int ST_TXE = 2;
	localparam int ST_BRK = 3;
	localparam int ST_OVR = 4;
	localparam int ST_FRM = 5;
	localparam int ST_TMR = 1;
	// control field positions
	localparam int CT_EN = 0;
	localparam int CT_RIE = 1;
	localparam int CT_TIE = 2;
	localparam int CT_EIE = 3;
	localparam int CT_MULTIDROP_ADDRESSING_ENABLE = 4;
	localparam int CT_MPAO = 5;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [7:0] ADDR_RST = 8'h00;
	// index of the last data bit shifted out; the stop bit follows at the next tick
	localparam int TX_LATENCY_BITS = 7;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SHIFT = 3'b010,
		TX_STOP = 3'b100
	} uio_tx_state_type;
endpackage : uio_pkg
`default_nettype wire

// ==== verilog/uio_buf_if.sv ====
// interface: valid/ready word path into the two-entry buffer
`timescale 1ns/100ps
`default_nettype none
interface uio_buf_if;
	logic valid;
	logic ready;
	logic [10:0] data; // address-byte mark, break, framing error, character
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : uio_buf_if
`default_nettype wire

// ==== verilog/uio_skid.sv ====
// module: two-entry buffer holding received characters and their flags
`timescale 1ns/100ps
`default_nettype none
module uio_skid (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// filling side
	uio_buf_if.snk in_if,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [10:0] out_data
);
	typedef struct packed {
		logic [1:0][10:0] mem;
		logic [1:0] cnt;
		logic rd;
		logic wr;
	} uio_skid_type;
	uio_skid_type st_r, st_nxt;

	assign in_if.ready = (st_r.cnt != 2'd2);
	assign out_valid = (st_r.cnt != 2'd0);
	assign out_data = st_r.mem[st_r.rd];

	// push and pop with honest occupancy
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		st_nxt = st_r;
		push = in_if.valid && (st_r.cnt != 2'd2);
		pop = out_ready && (st_r.cnt != 2'd0);
		if (push) begin
			st_nxt.mem[st_r.wr] = in_if.data;
			st_nxt.wr = ~st_r.wr;
		end
		if (pop) begin
			st_nxt.rd = ~st_r.rd;
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 2'd1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 2'd1;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // uio_skid
`default_nettype wire

// ==== verilog/uio_core.sv ====
// module: uart interrupt, transmit-empty and receive overrun handling
`timescale 1ns/100ps
`default_nettype none
module uio_core (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// serial line
	output logic txd,
	input wire logic rx_done,
	input wire logic [7:0] rx_char,
	input wire logic rx_frame_err,
	input wire logic rx_break,
	input wire logic rx_is_addr,
	output logic rx_ready,
	// interrupt requests
	output logic irq_tx,
	output logic irq_rx
);
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] ctrl;
		logic [15:0] div;
		logic [15:0] cnt;
		logic [7:0] my_addr;
		logic [7:0] thr;
		logic thr_full;
		logic tx_holding_empty;
		uio_pkg::uio_tx_state_type txs;
		logic [8:0] shreg;
		logic [3:0] bitn;
		logic txd;
		logic [7:0] rbuf;
		logic rx_byte_available;
		logic ovr_pending;
		logic brk_pending;
		logic overrun;
		logic break_seen;
		logic frame_err;
		logic tmr_flag;
		logic addr_match;
		logic irq_tx;
		logic irq_rx;
	} uio_core_type;
	uio_core_type st_r, st_nxt;

	uio_buf_if bif ();
	logic bo_valid;
	logic bo_ready;
	logic [10:0] bo_data;

	// incoming characters go through the buffer so a slow drain loses none;
	// the address-byte mark travels with its character, the pin may move on
	assign bif.valid = rx_done;
	assign bif.data = {rx_is_addr, rx_break, rx_frame_err, rx_char};
	assign rx_ready = bif.ready;

	uio_skid u_skid (
		.core_clk(core_clk),
		.srst(srst),
		.in_if(bif),
		.out_valid(bo_valid),
		.out_ready(bo_ready),
		.out_data(bo_data)
	);

	function automatic logic is_sel(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	// buffer drains one word per cycle into the receive data logic
	assign bo_ready = 1'b1;

	assign reg_rdata = st_r.rdata;
	assign txd = st_r.txd;
	assign irq_tx = st_r.irq_tx;
	assign irq_rx = st_r.irq_rx;

	// next-state logic for all registers
	always_comb begin
		logic tick;
		logic en;
		logic rd_data;
		logic rd_stat;
		logic rx_evt;
		logic rx_data_int;
		logic err_int;
		tick = 1'b0;
		en = 1'b0;
		rd_data = 1'b0;
		rd_stat = 1'b0;
		rx_evt = 1'b0;
		rx_data_int = 1'b0;
		err_int = 1'b0;
		st_nxt = st_r;
		st_nxt.irq_tx = 1'b0;
		st_nxt.irq_rx = 1'b0;
		en = st_r.ctrl[uio_pkg::CT_EN];

		// baud divider: bit-period tick, or timer when the port is off
		if (st_r.cnt >= st_r.div) begin
			st_nxt.cnt = 16'h0001;
			tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end
		if (tick && !en) begin
			st_nxt.tmr_flag = 1'b1;
		end

		// register writes
		if (reg_wr) begin
			if (is_sel(reg_addr, uio_pkg::ADDR_TXDATA)) begin
				st_nxt.thr = reg_wdata;
				st_nxt.thr_full = 1'b1;
				st_nxt.tx_holding_empty = 1'b0;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_CTRL)) begin
				st_nxt.ctrl = reg_wdata;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_DIVLO)) begin
				st_nxt.div[7:0] = reg_wdata;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_DIVHI)) begin
				st_nxt.div[15:8] = reg_wdata;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_ADDR)) begin
				st_nxt.my_addr = reg_wdata;
			end
		end

		// register reads, data one cycle later
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			if (is_sel(reg_addr, uio_pkg::ADDR_RXDATA)) begin
				st_nxt.rdata = st_r.rbuf;
				rd_data = 1'b1;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_STATUS)) begin
				st_nxt.rdata[uio_pkg::ST_RDA] = st_r.rx_byte_available;
				st_nxt.rdata[uio_pkg::ST_TXE] = st_r.tx_holding_empty;
				st_nxt.rdata[uio_pkg::ST_BRK] = st_r.break_seen;
				st_nxt.rdata[uio_pkg::ST_OVR] = st_r.overrun;
				st_nxt.rdata[uio_pkg::ST_FRM] = st_r.frame_err;
				st_nxt.rdata[uio_pkg::ST_TMR] = st_r.tmr_flag;
				rd_stat = 1'b1;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_CTRL)) begin
				st_nxt.rdata = st_r.ctrl;
			end else if (is_sel(reg_addr, uio_pkg::ADDR_DIVLO)) begin
				st_nxt.rdata = st_r.div[7:0];
			end else if (is_sel(reg_addr, uio_pkg::ADDR_DIVHI)) begin
				st_nxt.rdata = st_r.div[15:8];
			end else if (is_sel(reg_addr, uio_pkg::ADDR_ADDR)) begin
				st_nxt.rdata = st_r.my_addr;
			end
		end
		// status read clears the sticky error flags and timer flag
		if (rd_stat) begin
			st_nxt.overrun = 1'b0;
			st_nxt.break_seen = 1'b0;
			st_nxt.frame_err = 1'b0;
			st_nxt.tmr_flag = tick && !en; // a tick in the read cycle wins
		end

		// read of the pending byte releases deferred overrun status
		if (rd_data) begin
			st_nxt.rx_byte_available = 1'b0;
			if (st_r.ovr_pending) begin
				st_nxt.overrun = 1'b1;
				st_nxt.break_seen = st_r.brk_pending;
				st_nxt.rx_byte_available = 1'b1;
				st_nxt.ovr_pending = 1'b0;
				st_nxt.brk_pending = 1'b0;
			end
		end

		// receive side: new character from the buffer, set wins over clear
		if (bo_valid && en) begin
			rx_evt = 1'b1;
			if (st_r.rx_byte_available && !rd_data) begin
				st_nxt.ovr_pending = 1'b1;
				st_nxt.brk_pending = bo_data[9];
				err_int = 1'b1;
			end else begin
				st_nxt.rbuf = bo_data[7:0];
				st_nxt.rx_byte_available = 1'b1;
				st_nxt.frame_err = st_nxt.frame_err | bo_data[8];
				st_nxt.break_seen = st_nxt.break_seen | bo_data[9];
				err_int = bo_data[8] | bo_data[9];
				rx_data_int = 1'b1;
			end
			// multidrop: address bytes update the match, data gated by it
			if (st_r.ctrl[uio_pkg::CT_MULTIDROP_ADDRESSING_ENABLE]) begin
				if (bo_data[10]) begin
					st_nxt.addr_match = (bo_data[7:0] == st_r.my_addr);
					rx_data_int = rx_data_int && !st_r.ctrl[uio_pkg::CT_MPAO];
				end else begin
					rx_data_int = rx_data_int && st_r.addr_match;
				end
			end
		end

		// receive interrupt: data source and error sources enabled apart
		st_nxt.irq_rx = (rx_evt && rx_data_int && st_r.ctrl[uio_pkg::CT_RIE])
			|| (err_int && st_r.ctrl[uio_pkg::CT_EIE])
			|| (rd_data && st_r.ovr_pending && st_r.ctrl[uio_pkg::CT_EIE])
			|| (tick && !en && st_r.ctrl[uio_pkg::CT_RIE]);

		// transmitter: empty flag rises after the start bit leaves
		case (st_r.txs)
			uio_pkg::TX_IDLE: begin
				st_nxt.txd = 1'b1;
				if (en && st_r.thr_full && tick) begin
					st_nxt.shreg = {st_r.thr, 1'b0};
					st_nxt.bitn = 4'd0;
					st_nxt.txs = uio_pkg::TX_SHIFT;
					st_nxt.txd = 1'b0;
				end
			end
			uio_pkg::TX_SHIFT: begin
				if (tick) begin
					if (st_r.bitn == 4'd0 && !(reg_wr && is_sel(reg_addr, uio_pkg::ADDR_TXDATA))) begin
						st_nxt.thr_full = 1'b0;
						st_nxt.tx_holding_empty = 1'b1;
						st_nxt.irq_tx = st_r.ctrl[uio_pkg::CT_TIE];
					end
					st_nxt.shreg = {1'b1, st_r.shreg[8:1]};
					st_nxt.txd = st_r.shreg[1];
					st_nxt.bitn = st_r.bitn + 4'd1;
					if (st_r.bitn == 4'(uio_pkg::TX_LATENCY_BITS + 1)) begin
						st_nxt.txd = 1'b1;
						st_nxt.txs = uio_pkg::TX_STOP;
					end
				end
			end
			uio_pkg::TX_STOP: begin
				if (tick) begin
					st_nxt.txs = uio_pkg::TX_IDLE;
				end
			end
			default: begin
				st_nxt.txs = uio_pkg::TX_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.ctrl <= uio_pkg::CTRL_RST;
			st_r.div <= uio_pkg::DIV_RST;
			st_r.my_addr <= uio_pkg::ADDR_RST;
			st_r.cnt <= 16'h0001;
			st_r.txs <= uio_pkg::TX_IDLE;
			st_r.txd <= 1'b1;
			st_r.tx_holding_empty <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // uio_core
`default_nettype wire

// ==== tb/uio_peer.sv ====
// model: remote receiver handing finished characters to the core
`timescale 1ns/100ps
`default_nettype none
module uio_peer (
	// clock
	input wire logic core_clk,
	// character hand-over
	input wire logic rx_ready,
	output logic rx_done,
	output logic [7:0] rx_char,
	output logic rx_frame_err,
	output logic rx_break,
	output logic rx_is_addr
);
	// nothing offered at start
	initial begin
		rx_done = 1'b0;
		rx_char = 8'h00;
		rx_frame_err = 1'b0;
		rx_break = 1'b0;
		rx_is_addr = 1'b0;
	end
	// offer a character after a gap once the buffer has room, then scramble the lines
	task automatic send(input int gap, input logic [7:0] c, input logic fe, input logic brk,
		input logic ad);
		repeat (gap) @(posedge core_clk);
		@(negedge core_clk);
		while (rx_ready !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
		rx_done <= 1'b1;
		rx_char <= c;
		rx_frame_err <= fe;
		rx_break <= brk;
		rx_is_addr <= ad;
		@(posedge core_clk);
		rx_done <= 1'b0;
		rx_char <= ~c;
		rx_frame_err <= ~fe;
		rx_break <= ~brk;
		rx_is_addr <= ~ad;
	endtask
endmodule // uio_peer
`default_nettype wire

// ==== tb/uio_core_asserts.sv ====
// checker: port-level assertions on the uart interrupt and overrun core
`timescale 1ns/100ps
`default_nettype none
module uio_core_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// line and interrupts
	input wire logic txd,
	input wire logic rx_done,
	input wire logic rx_frame_err,
	input wire logic rx_ready,
	input wire logic irq_tx,
	input wire logic irq_rx
);
	logic [7:0] ctrl_r;
	logic tie_w;
	logic rie_w;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// shadow of the control register as written at the port
	always_ff @(posedge core_clk) begin
		if (srst)
			ctrl_r <= uio_pkg::CTRL_RST;
		else if (reg_wr && reg_addr == uio_pkg::ADDR_CTRL)
			ctrl_r <= reg_wdata;
	end
	// enables behind each interrupt line
	assign tie_w = ctrl_r[uio_pkg::CT_TIE];
	assign rie_w = ctrl_r[uio_pkg::CT_RIE] | ctrl_r[uio_pkg::CT_EIE];
	sequence s_tx_wr; reg_wr && reg_addr == uio_pkg::ADDR_TXDATA; endsequence
	sequence s_st_rd; reg_rd && reg_addr == uio_pkg::ADDR_STATUS; endsequence
	property p_reset_out;
		disable iff (1'b0) srst |=> txd && !irq_tx && !irq_rx && reg_rdata == 8'h00 && rx_ready;
	endproperty
	property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	property p_unmapped; reg_rd && reg_addr > uio_pkg::ADDR_ADDR |=> reg_rdata == 8'h00; endproperty
	property p_tx_pulse; irq_tx |=> !irq_tx; endproperty
	property p_tx_gate; !tie_w && !$past(tie_w) && !$past(tie_w, 2) |-> !irq_tx; endproperty
	property p_rx_gate; !rie_w && !$past(rie_w) && !$past(rie_w, 2) |-> !irq_rx; endproperty
	property p_txe_clear; s_tx_wr ##1 s_st_rd |=> !reg_rdata[uio_pkg::ST_TXE]; endproperty
	property p_frame_irq;
		rx_done && rx_ready && rx_frame_err && ctrl_r[uio_pkg::CT_EN] && ctrl_r[uio_pkg::CT_EIE]
			|-> ##[1:6] irq_rx;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_tx_pulse: assert property (p_tx_pulse) else $error("tx irq longer than a cycle");
	a_tx_gate: assert property (p_tx_gate) else $error("tx irq while disabled");
	a_rx_gate: assert property (p_rx_gate) else $error("rx irq while disabled");
	a_txe_clear: assert property (p_txe_clear) else $error("empty flag kept after write");
	a_frame_irq: assert property (p_frame_irq) else $error("no irq on framing error");
endmodule // uio_core_asserts
bind uio_core uio_core_asserts chk_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd),
	.rx_done(rx_done), .rx_frame_err(rx_frame_err), .rx_ready(rx_ready), .irq_tx(irq_tx),
	.irq_rx(irq_rx));
`default_nettype wire

// ==== tb/tb_uart_interrupt_overrun_logic.sv ====
// testbench: registers, interrupts and overrun handling of the uart core
`timescale 1ns/100ps
`default_nettype none
module tb_uart_interrupt_overrun_logic;
	localparam logic [3:0] ST = uio_pkg::ADDR_STATUS;
	localparam logic [3:0] RX = uio_pkg::ADDR_RXDATA;
	localparam logic [3:0] CT = uio_pkg::ADDR_CTRL;
	typedef struct {logic [3:0] a; logic [7:0] m; logic [7:0] e;} uio_row_type;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic txd;
	logic rx_done;
	logic [7:0] rx_char;
	logic rx_frame_err;
	logic rx_break;
	logic rx_is_addr;
	logic rx_ready;
	logic irq_tx;
	logic irq_rx;
	logic [7:0] v;
	logic start_seen = 1'b0;
	int miscompares = 0;
	int checked = 0;
	// reset contents: ctrl, divider low and high, own address, unmapped, status (timer masked)
	uio_row_type rows [6] = '{'{CT, 8'hff, 8'h00}, '{4'h4, 8'hff, 8'h01}, '{4'h5, 8'hff, 8'h00},
		'{4'h6, 8'hff, 8'h00}, '{4'hf, 8'hff, 8'h00}, '{ST, 8'hfd, 8'h04}};
	always #4 core_clk = ~core_clk;
	uio_core dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rx_done(rx_done),
		.rx_char(rx_char), .rx_frame_err(rx_frame_err), .rx_break(rx_break),
		.rx_is_addr(rx_is_addr), .rx_ready(rx_ready), .irq_tx(irq_tx), .irq_rx(irq_rx));
	uio_peer peer_u (.core_clk(core_clk), .rx_ready(rx_ready), .rx_done(rx_done),
		.rx_char(rx_char), .rx_frame_err(rx_frame_err), .rx_break(rx_break),
		.rx_is_addr(rx_is_addr));
	// notes when the start bit leaves
	always @(negedge core_clk) if (txd === 1'b0) start_seen = 1'b1;
	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		v = reg_rdata;
	endtask
	// waits up to lim cycles for an interrupt pulse and compares whether one came
	task automatic wirq(input logic tx, input int lim, input logic e, input string n);
		logic hit;
		int k;
		hit = 1'b0;
		for (k = 0; k < lim && !hit; k++) begin
			@(negedge core_clk);
			hit = ((tx ? irq_tx : irq_rx) === 1'b1);
		end
		chk(n, {7'h00, e}, {7'h00, hit});
	endtask
	initial begin
		repeat (10000) @(posedge core_clk);
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(rows[i].a);
			chk("reset register", rows[i].e, v & rows[i].m);
		end
		// divider as timer while the port is off
		wr(CT, 8'h02);
		wirq(1'b1 ^ 1'b1, 200, 1'b1, "timer irq");
		rd(ST);
		chk("timer flag", 8'h02, v & 8'h02);
		// transmit write followed at once by a status read
		wr(CT, 8'h0f);
		start_seen = 1'b0;
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= uio_pkg::ADDR_TXDATA;
		reg_wdata <= 8'h5a;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= ST;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk("empty after write", 8'h00, reg_rdata & 8'h04);
		wirq(1'b1, 400, 1'b1, "tx irq");
		chk("start before irq", 8'h01, {7'h00, start_seen});
		wirq(1'b1, 300, 1'b0, "second tx irq");
		// plain received byte
		peer_u.send(0, 8'h3c, 1'b0, 1'b0, 1'b0);
		wirq(1'b0, 20, 1'b1, "rx irq");
		rd(ST);
		chk("available", 8'h80, v & 8'h80);
		rd(RX);
		chk("rx byte", 8'h3c, v);
		// second character, a break, lands on an unread one
		peer_u.send(0, 8'h11, 1'b0, 1'b0, 1'b0);
		peer_u.send(3, 8'h22, 1'b0, 1'b1, 1'b0);
		repeat (6) @(posedge core_clk);
		rd(ST);
		chk("held status", 8'h80, v & 8'h98);
		rd(RX);
		chk("kept byte", 8'h11, v);
		rd(ST);
		chk("overrun status", 8'h98, v & 8'h98);
		rd(RX);
		// framing error
		peer_u.send(0, 8'h00, 1'b1, 1'b0, 1'b0);
		repeat (6) @(posedge core_clk);
		rd(ST);
		chk("frame flag", 8'ha0, v & 8'ha0);
		rd(RX);
		// multidrop: data raises no interrupt until own address arrives
		wr(uio_pkg::ADDR_ADDR, 8'h42);
		wr(CT, 8'h13);
		peer_u.send(0, 8'h55, 1'b0, 1'b0, 1'b0);
		wirq(1'b0, 20, 1'b0, "unaddressed irq");
		rd(RX);
		peer_u.send(0, 8'h42, 1'b0, 1'b0, 1'b1);
		repeat (6) @(posedge core_clk);
		rd(RX);
		peer_u.send(0, 8'h66, 1'b0, 1'b0, 1'b0);
		wirq(1'b0, 20, 1'b1, "addressed irq");
		wrap_up;
	end
endmodule // tb_uart_interrupt_overrun_logic
`default_nettype wire
